/* File: core/ttc_core.sv */
// Thermometer and thermostat core with three-wire port and register slave
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module ttc_core #(
	parameter int CONVERT_START_LOW_MAX_CYCLES = ttc_pkg::CONVERT_START_LOW_MAX_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register bus
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Three-wire port
	input wire logic clock_or_convert_pin_in,
	input wire logic port_reset_in,
	input wire logic data_in,
	output logic data_out,
	output logic data_oe_n_out,
	// Oscillators
	input wire logic low_tc_osc_in,
	input wire logic high_tc_osc_in,
	// Thermostat outputs
	output logic above_limit_alarm_out,
	output logic below_limit_alarm_out,
	output logic hysteresis_alarm_out
);

	function automatic logic [8:0] merge9(input logic [8:0] old, input logic [31:0] d, input logic [3:0] s);
		merge9 = {s[1] ? d[8] : old[8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a <= ttc_pkg::OFS_COUNT);
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] sync1, sync2, sync3, stable, stable_prev, next_stable;
	always_comb begin
		for (int i = 0; i < ttc_pkg::PIN_N; i++) begin
			next_stable[i] = (sync2[i] == sync3[i]) ? sync3[i] : stable[i];
		end
	end
	always_ff @(posedge clk_in) begin
		sync1 <= {high_tc_osc_in, low_tc_osc_in, data_in, port_reset_in, clock_or_convert_pin_in};
		sync2 <= sync1;
		sync3 <= sync2;
		if (rst_in) begin
			stable <= 5'h01;
			stable_prev <= 5'h01;
		end else begin
			stable <= next_stable;
			stable_prev <= stable;
		end
	end
	logic p_clk, p_rst, p_dq, clk_rise, clk_fall, losc_edge, hosc_edge;
	assign p_clk = stable[ttc_pkg::PIN_CLK];
	assign p_rst = stable[ttc_pkg::PIN_RST];
	assign p_dq = stable[ttc_pkg::PIN_DQ];
	assign clk_rise = p_clk && !stable_prev[ttc_pkg::PIN_CLK];
	assign clk_fall = !p_clk && stable_prev[ttc_pkg::PIN_CLK];
	assign losc_edge = stable[ttc_pkg::PIN_LOSC] && !stable_prev[ttc_pkg::PIN_LOSC];
	assign hosc_edge = stable[ttc_pkg::PIN_HOSC] && !stable_prev[ttc_pkg::PIN_HOSC];

	// ----------------------------------------
	// Register bus slave
	// ----------------------------------------
	logic aw_held, w_held, next_aw_held, next_w_held, next_awready, next_wready, next_bvalid;
	logic next_arready, next_rvalid, wr_go;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data, rd_word, next_rdata;
	logic [3:0] w_strb, next_w_strb;
	logic [1:0] next_bresp, next_rresp;
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_awready = s_axi_awready_out;
		next_wready = s_axi_wready_out;
		next_bvalid = s_axi_bvalid_out;
		next_bresp = s_axi_bresp_out;
		next_arready = s_axi_arready_out;
		next_rvalid = s_axi_rvalid_out;
		next_rdata = s_axi_rdata_out;
		next_rresp = s_axi_rresp_out;
		wr_go = aw_held && w_held && !s_axi_bvalid_out;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_in;
			next_awready = 1'b0;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata_in;
			next_w_strb = s_axi_wstrb_in;
			next_wready = 1'b0;
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(aw_addr) ? ttc_pkg::RESP_OKAY : ttc_pkg::RESP_SLVERR;
		end
		if (s_axi_bvalid_out && s_axi_bready_in) begin
			next_bvalid = 1'b0;
			next_awready = 1'b1;
			next_wready = 1'b1;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			next_arready = 1'b0;
			next_rvalid = 1'b1;
			next_rdata = mapped(s_axi_araddr_in) ? rd_word : 32'h0000_0000;
			next_rresp = mapped(s_axi_araddr_in) ? ttc_pkg::RESP_OKAY : ttc_pkg::RESP_SLVERR;
		end
		if (s_axi_rvalid_out && s_axi_rready_in) begin
			next_rvalid = 1'b0;
			next_arready = 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= ttc_pkg::RESP_OKAY;
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= ttc_pkg::RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready_out <= next_awready;
			s_axi_wready_out <= next_wready;
			s_axi_bvalid_out <= next_bvalid;
			s_axi_bresp_out <= next_bresp;
			s_axi_arready_out <= next_arready;
			s_axi_rvalid_out <= next_rvalid;
			s_axi_rdata_out <= next_rdata;
			s_axi_rresp_out <= next_rresp;
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic host_mode, single_conversion_bit, next_host_mode, next_single;
	logic [8:0] upper_limit, lower_limit, base_count, slope_init, slope_step, gate_len;
	logic [8:0] next_upper, next_lower, next_base, next_slope_init, next_slope_step, next_gate_len;
	logic ax_start, ax_stop, ser_start, ser_stop, ser_wr_upper, ser_wr_lower, ser_ld_slope;
	logic [8:0] ser_word;
	always_comb begin
		next_host_mode = host_mode;
		next_single = single_conversion_bit;
		next_upper = upper_limit;
		next_lower = lower_limit;
		next_base = base_count;
		next_slope_init = slope_init;
		next_slope_step = slope_step;
		next_gate_len = gate_len;
		ax_start = 1'b0;
		ax_stop = 1'b0;
		if (wr_go && w_strb[0]) begin
			case (aw_addr)
				ttc_pkg::OFS_CTRL: begin
					next_host_mode = w_data[ttc_pkg::CTRL_HOST];
					next_single = w_data[ttc_pkg::CTRL_SINGLE];
					ax_start = w_data[ttc_pkg::CTRL_START];
					ax_stop = w_data[ttc_pkg::CTRL_STOP];
				end
				default: begin
				end
			endcase
		end
		if (wr_go) begin
			case (aw_addr)
				ttc_pkg::OFS_UPPER: next_upper = merge9(upper_limit, w_data, w_strb);
				ttc_pkg::OFS_LOWER: next_lower = merge9(lower_limit, w_data, w_strb);
				ttc_pkg::OFS_BASE: next_base = merge9(base_count, w_data, w_strb);
				ttc_pkg::OFS_SLOPE_INIT: next_slope_init = merge9(slope_init, w_data, w_strb);
				ttc_pkg::OFS_SLOPE_STEP: next_slope_step = merge9(slope_step, w_data, w_strb);
				ttc_pkg::OFS_GATE_LEN: next_gate_len = merge9(gate_len, w_data, w_strb);
				default: begin
				end
			endcase
		end
		if (ser_wr_upper) begin
			next_upper = ser_word;
		end
		if (ser_wr_lower) begin
			next_lower = ser_word;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			host_mode <= 1'b0;
			single_conversion_bit <= 1'b0;
			upper_limit <= ttc_pkg::UPPER_RST;
			lower_limit <= ttc_pkg::LOWER_RST;
			base_count <= ttc_pkg::BASE_RST;
			slope_init <= ttc_pkg::SLOPE_INIT_RST;
			slope_step <= ttc_pkg::SLOPE_STEP_RST;
			gate_len <= ttc_pkg::GATE_LEN_RST;
		end else begin
			host_mode <= next_host_mode;
			single_conversion_bit <= next_single;
			upper_limit <= next_upper;
			lower_limit <= next_lower;
			base_count <= next_base;
			slope_init <= next_slope_init;
			slope_step <= next_slope_step;
			gate_len <= next_gate_len;
		end
	end

	// ----------------------------------------
	// Conversion engine
	// ----------------------------------------
	ttc_pkg::ttc_convert_start_low_t cv_state, next_cv_state;
	logic [8:0] counter, slope_acc, temp_acc, result, count_reg, gate_cnt;
	logic [8:0] next_counter, next_slope_acc, next_temp_acc, next_result, next_count_reg, next_gate_cnt;
	logic [23:0] time_cnt, next_time_cnt;
	logic done, run_on, next_done, next_run_on, next_above, next_below, next_hyst, sa_mode, gate_end;
	always_comb begin
		next_cv_state = cv_state;
		next_counter = counter;
		next_slope_acc = slope_acc;
		next_temp_acc = temp_acc;
		next_result = result;
		next_count_reg = count_reg;
		next_gate_cnt = gate_cnt;
		next_time_cnt = time_cnt;
		next_done = done;
		next_run_on = run_on;
		next_above = above_limit_alarm_out;
		next_below = below_limit_alarm_out;
		next_hyst = hysteresis_alarm_out;
		sa_mode = !host_mode && !p_rst;
		gate_end = 1'b0;
		if (ax_start || ser_start) begin
			next_run_on = !next_single;
		end
		if (ax_stop || ser_stop) begin
			next_run_on = 1'b0;
		end
		if (ser_ld_slope) begin
			next_count_reg = slope_acc;
		end
		case (cv_state)
			ttc_pkg::CV_IDLE: begin
				if (ax_start || ser_start || run_on || (sa_mode && (clk_fall || !p_clk))) begin
					next_counter = base_count;
					next_temp_acc = ttc_pkg::TEMP_MIN;
					next_slope_acc = slope_init;
					next_gate_cnt = 9'h000;
					next_time_cnt = 24'h000000;
					next_done = 1'b0;
					next_cv_state = ttc_pkg::CV_GATE;
				end
			end
			ttc_pkg::CV_GATE: begin
				next_time_cnt = time_cnt + 24'h000001;
				if (hosc_edge) begin
					next_gate_cnt = gate_cnt + 9'h001;
				end
				if (losc_edge) begin
					if (counter <= 9'h001) begin
						next_counter = slope_acc;
						next_slope_acc = slope_acc + slope_step;
						if (temp_acc != ttc_pkg::TEMP_MAX) begin
							next_temp_acc = temp_acc + 9'h001;
						end
					end else begin
						next_counter = counter - 9'h001;
					end
				end
				gate_end = (hosc_edge && next_gate_cnt >= gate_len) ||
					(time_cnt >= 24'(CONVERT_START_LOW_MAX_CYCLES - 1));
				if (gate_end) begin
					next_result = next_temp_acc;
					next_count_reg = next_counter;
					next_above = $signed(next_temp_acc) >= $signed(upper_limit);
					next_below = $signed(next_temp_acc) <= $signed(lower_limit);
					if ($signed(next_temp_acc) >= $signed(upper_limit)) begin
						next_hyst = 1'b1;
					end else if ($signed(next_temp_acc) <= $signed(lower_limit)) begin
						next_hyst = 1'b0;
					end
					next_done = 1'b1;
					next_cv_state = ttc_pkg::CV_IDLE;
				end
			end
			default: next_cv_state = ttc_pkg::CV_IDLE;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cv_state <= ttc_pkg::CV_IDLE;
			counter <= 9'h000;
			slope_acc <= 9'h000;
			temp_acc <= ttc_pkg::TEMP_MIN;
			result <= ttc_pkg::TEMP_MIN;
			count_reg <= 9'h000;
			gate_cnt <= 9'h000;
			time_cnt <= 24'h000000;
			done <= 1'b0;
			run_on <= 1'b0;
			above_limit_alarm_out <= 1'b0;
			below_limit_alarm_out <= 1'b0;
			hysteresis_alarm_out <= 1'b0;
		end else begin
			cv_state <= next_cv_state;
			counter <= next_counter;
			slope_acc <= next_slope_acc;
			temp_acc <= next_temp_acc;
			result <= next_result;
			count_reg <= next_count_reg;
			gate_cnt <= next_gate_cnt;
			time_cnt <= next_time_cnt;
			done <= next_done;
			run_on <= next_run_on;
			above_limit_alarm_out <= next_above;
			below_limit_alarm_out <= next_below;
			hysteresis_alarm_out <= next_hyst;
		end
	end

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always_comb begin
		case (s_axi_araddr_in)
			ttc_pkg::OFS_CTRL: rd_word = {30'h0, single_conversion_bit, host_mode};
			ttc_pkg::OFS_UPPER: rd_word = {23'h0, upper_limit};
			ttc_pkg::OFS_LOWER: rd_word = {23'h0, lower_limit};
			ttc_pkg::OFS_BASE: rd_word = {23'h0, base_count};
			ttc_pkg::OFS_SLOPE_INIT: rd_word = {23'h0, slope_init};
			ttc_pkg::OFS_SLOPE_STEP: rd_word = {23'h0, slope_step};
			ttc_pkg::OFS_GATE_LEN: rd_word = {23'h0, gate_len};
			ttc_pkg::OFS_RESULT: rd_word = {23'h0, result};
			ttc_pkg::OFS_STATUS: rd_word = {27'h0, hysteresis_alarm_out, below_limit_alarm_out,
				above_limit_alarm_out, cv_state == ttc_pkg::CV_GATE, done};
			ttc_pkg::OFS_COUNT: rd_word = {23'h0, count_reg};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Three-wire serial port
	// ----------------------------------------
	ttc_pkg::ttc_ser_t ser_state, next_ser_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] cmd_sh, next_cmd_sh, cmd_full;
	logic [8:0] io_sh, next_io_sh;
	logic next_data, next_oe_n;
	always_comb begin
		next_ser_state = ser_state;
		next_bit_cnt = bit_cnt;
		next_cmd_sh = cmd_sh;
		next_io_sh = io_sh;
		next_data = data_out;
		next_oe_n = data_oe_n_out;
		ser_start = 1'b0;
		ser_stop = 1'b0;
		ser_wr_upper = 1'b0;
		ser_wr_lower = 1'b0;
		ser_ld_slope = 1'b0;
		cmd_full = {p_dq, cmd_sh[7:1]};
		ser_word = {p_dq, io_sh[8:1]};
		if (!p_rst) begin
			next_ser_state = ttc_pkg::SR_IDLE;
			next_oe_n = 1'b1;
		end else begin
			case (ser_state)
				ttc_pkg::SR_IDLE: begin
					next_bit_cnt = 4'h0;
					next_ser_state = ttc_pkg::SR_CMD;
				end
				ttc_pkg::SR_CMD: begin
					if (clk_rise) begin
						next_cmd_sh = cmd_full;
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == 4'h7) begin
							next_bit_cnt = 4'h0;
							next_ser_state = ttc_pkg::SR_READ;
							case (cmd_full)
								ttc_pkg::CMD_READ_TEMP: next_io_sh = result;
								ttc_pkg::CMD_READ_COUNT: next_io_sh = count_reg;
								ttc_pkg::CMD_READ_SLOPE: begin
									next_io_sh = slope_acc;
									ser_ld_slope = 1'b1;
								end
								ttc_pkg::CMD_READ_UPPER: next_io_sh = upper_limit;
								ttc_pkg::CMD_READ_LOWER: next_io_sh = lower_limit;
								ttc_pkg::CMD_WRITE_UPPER, ttc_pkg::CMD_WRITE_LOWER: begin
									next_ser_state = ttc_pkg::SR_WRITE;
								end
								ttc_pkg::CMD_START: begin
									ser_start = 1'b1;
									next_ser_state = ttc_pkg::SR_HOLD;
								end
								ttc_pkg::CMD_STOP: begin
									ser_stop = 1'b1;
									next_ser_state = ttc_pkg::SR_HOLD;
								end
								default: next_ser_state = ttc_pkg::SR_HOLD;
							endcase
						end
					end
				end
				ttc_pkg::SR_READ: begin
					if (clk_fall) begin
						next_data = io_sh[0];
						next_oe_n = 1'b0;
						next_io_sh = {1'b0, io_sh[8:1]};
					end else if (clk_rise) begin
						next_oe_n = 1'b1;
					end
				end
				ttc_pkg::SR_WRITE: begin
					if (clk_rise) begin
						next_io_sh = ser_word;
						next_bit_cnt = bit_cnt + 4'h1;
						if (bit_cnt == 4'h8) begin
							ser_wr_upper = cmd_sh == ttc_pkg::CMD_WRITE_UPPER;
							ser_wr_lower = cmd_sh == ttc_pkg::CMD_WRITE_LOWER;
							next_ser_state = ttc_pkg::SR_HOLD;
						end
					end
				end
				ttc_pkg::SR_HOLD: next_oe_n = 1'b1;
				default: next_ser_state = ttc_pkg::SR_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ser_state <= ttc_pkg::SR_IDLE;
			bit_cnt <= 4'h0;
			cmd_sh <= 8'h00;
			io_sh <= 9'h000;
			data_out <= 1'b0;
			data_oe_n_out <= 1'b1;
		end else begin
			ser_state <= next_ser_state;
			bit_cnt <= next_bit_cnt;
			cmd_sh <= next_cmd_sh;
			io_sh <= next_io_sh;
			data_out <= next_data;
			data_oe_n_out <= next_oe_n;
		end
	end

endmodule

/* File: core/ttc_pkg.sv */
// Constants and types shared by the thermometer and thermostat core
package ttc_pkg;

	// ----------------------------------------
	// Temperature encoding
	// ----------------------------------------
	localparam int TEMP_W = 9;
	localparam logic [8:0] TEMP_MIN = 9'h192;
	localparam logic [8:0] TEMP_MAX = 9'h0FA;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_UPPER = 8'h04;
	localparam logic [7:0] OFS_LOWER = 8'h08;
	localparam logic [7:0] OFS_BASE = 8'h0C;
	localparam logic [7:0] OFS_SLOPE_INIT = 8'h10;
	localparam logic [7:0] OFS_SLOPE_STEP = 8'h14;
	localparam logic [7:0] OFS_GATE_LEN = 8'h18;
	localparam logic [7:0] OFS_RESULT = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_COUNT = 8'h24;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_HOST = 0;
	localparam int CTRL_SINGLE = 1;
	localparam int CTRL_START = 2;
	localparam int CTRL_STOP = 3;
	localparam int ST_DONE = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_ABOVE = 2;
	localparam int ST_BELOW = 3;
	localparam int ST_HYST = 4;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [8:0] UPPER_RST = 9'h032;
	localparam logic [8:0] LOWER_RST = 9'h000;
	localparam logic [8:0] BASE_RST = 9'h040;
	localparam logic [8:0] SLOPE_INIT_RST = 9'h020;
	localparam logic [8:0] SLOPE_STEP_RST = 9'h000;
	localparam logic [8:0] GATE_LEN_RST = 9'h064;

	// ----------------------------------------
	// Serial commands
	// ----------------------------------------
	localparam logic [7:0] CMD_READ_TEMP = 8'hAA;
	localparam logic [7:0] CMD_READ_COUNT = 8'hA0;
	localparam logic [7:0] CMD_READ_SLOPE = 8'hA9;
	localparam logic [7:0] CMD_READ_UPPER = 8'hA1;
	localparam logic [7:0] CMD_READ_LOWER = 8'hA2;
	localparam logic [7:0] CMD_WRITE_UPPER = 8'h01;
	localparam logic [7:0] CMD_WRITE_LOWER = 8'h02;
	localparam logic [7:0] CMD_START = 8'hEE;
	localparam logic [7:0] CMD_STOP = 8'h22;

	// ----------------------------------------
	// Bus answers and timing
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_HZ = 10000000;
	localparam int CONVERT_START_LOW_MAX_S = 1;
	localparam int CONVERT_START_LOW_MAX_CYCLES = CONVERT_START_LOW_MAX_S * CLK_HZ;

	// ----------------------------------------
	// Pin synchroniser lanes
	// ----------------------------------------
	localparam int PIN_CLK = 0;
	localparam int PIN_RST = 1;
	localparam int PIN_DQ = 2;
	localparam int PIN_LOSC = 3;
	localparam int PIN_HOSC = 4;
	localparam int PIN_N = 5;

	// ----------------------------------------
	// State machines
	// ----------------------------------------
	typedef enum logic [1:0] {CV_IDLE = 2'h1, CV_GATE = 2'h2} ttc_convert_start_low_t;
	typedef enum logic [4:0] {
		SR_IDLE = 5'h01, SR_CMD = 5'h02, SR_READ = 5'h04, SR_WRITE = 5'h08, SR_HOLD = 5'h10
	} ttc_ser_t;

endpackage

/* File: tb/ttc_props.sv */
// Port checker for the thermometer core
`timescale 1ns/1ns
module ttc_props(
	input wire logic clk_in, rst_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out,
	input wire logic clock_or_convert_pin_in, port_reset_in, data_oe_n_out,
	input wire logic above_limit_alarm_out, below_limit_alarm_out, hysteresis_alarm_out
);
	// --------
	// Alarm, link and bus relations
	// --------
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [2:0] alm;
	assign alm = {above_limit_alarm_out, below_limit_alarm_out, hysteresis_alarm_out};
	a_above_hyst: assert property (above_limit_alarm_out |-> hysteresis_alarm_out)
		else $error("above alarm without hysteresis alarm");
	a_hyst_rise: assert property ($rose(hysteresis_alarm_out) |-> above_limit_alarm_out)
		else $error("hysteresis set below upper limit");
	a_hyst_fall: assert property ($fell(hysteresis_alarm_out) |-> below_limit_alarm_out)
		else $error("hysteresis cleared above lower limit");
	a_below_clear: assert property (below_limit_alarm_out && !above_limit_alarm_out |-> !hysteresis_alarm_out)
		else $error("hysteresis kept at lower limit");
	a_alarm_steady: assert property ($changed(alm) |=> $stable(alm) [*4])
		else $error("alarms changed twice within a gate");
	a_port_idle: assert property (!port_reset_in [*6] |-> data_oe_n_out)
		else $error("data driven while port reset low");
	a_clk_high_idle: assert property (clock_or_convert_pin_in [*7] |-> data_oe_n_out)
		else $error("data driven while serial clock high");
	a_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
endmodule
bind ttc_core ttc_props u_props(.clk_in, .rst_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
	.clock_or_convert_pin_in, .port_reset_in, .data_oe_n_out, .above_limit_alarm_out, .below_limit_alarm_out,
	.hysteresis_alarm_out);

/* File: tb/ttc_host_model.sv */
// Host model driving the three-wire port
`timescale 1ns/1ns
module ttc_host_model(
	// Pins toward the core
	output logic sclk_out,
	output logic prst_out,
	output logic dq_out,
	// Core data driver
	input wire logic dev_dq_in,
	input wire logic dev_oe_n_in
);
	// --------
	// Line level and transfers
	// --------
	logic hv;
	// Undriven line shows a changing pattern
	assign dq_out = dev_oe_n_in ? hv : dev_dq_in;
	initial begin
		sclk_out = 1'b1;
		prst_out = 1'b0;
		hv = 1'b0;
	end
	task automatic bitx(input logic w, input logic wr, output logic r);
		sclk_out = 1'b0;
		hv = wr ? w : ~hv;
		#400 sclk_out = 1'b1;
		#200 r = dq_out;
		#200;
	endtask
	task automatic xfer(input logic [7:0] cmd, input logic wr, input logic [8:0] wv, input int n,
		output logic [15:0] rv);
		logic b;
		rv = '0;
		#37 prst_out = 1'b1;
		#400;
		for (int i = 0; i < 8; i++)
			bitx(cmd[i], 1'b1, b);
		for (int i = 0; i < n; i++) begin
			bitx(wv[i % 9], wr, b);
			rv[i] = b;
		end
		#400 prst_out = 1'b0;
		#800;
	endtask
	task automatic convert_start_low_pulse;
		#37 sclk_out = 1'b0;
		#1000 sclk_out = 1'b1;
		#1000;
	endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the thermometer core
`timescale 1ns/1ns
module tb_top;
	logic clk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic clock_or_convert_pin_in, port_reset_in, data_in, data_out, data_oe_n_out, low_tc_osc_in, high_tc_osc_in;
	logic above_limit_alarm_out, below_limit_alarm_out, hysteresis_alarm_out;
	logic [15:0] rv;
	int n_fail = 0;
	int cmp_count = 0;
	ttc_core #(.CONVERT_START_LOW_MAX_CYCLES(2000)) u_dut(.clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
		.s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
		.s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
		.clock_or_convert_pin_in, .port_reset_in, .data_in, .data_out, .data_oe_n_out, .low_tc_osc_in,
		.high_tc_osc_in, .above_limit_alarm_out, .below_limit_alarm_out, .hysteresis_alarm_out);
	ttc_host_model u_host(.sclk_out(clock_or_convert_pin_in), .prst_out(port_reset_in), .dq_out(data_in),
		.dev_dq_in(data_out), .dev_oe_n_in(data_oe_n_out));
	// --------
	// Shared tasks
	// --------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] eb = ttc_pkg::RESP_OKAY);
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= 4'hF;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		s_axi_bready_in <= 1'b0;
		chk("bresp", 32'(eb), 32'(s_axi_bresp_out));
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = ttc_pkg::RESP_OKAY);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		s_axi_rready_in <= 1'b0;
		chk("rdata", e, s_axi_rdata_out);
		chk("rresp", 32'(er), 32'(s_axi_rresp_out));
	endtask
	task automatic osc(input int n, input logic h);
		repeat (n) begin
			@(posedge clk_in);
			if (h) high_tc_osc_in <= 1'b1;
			else low_tc_osc_in <= 1'b1;
			repeat (4) @(posedge clk_in);
			high_tc_osc_in <= 1'b0;
			low_tc_osc_in <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
	endtask
	task automatic convert_start_low(input int n, input logic [8:0] et, input logic [8:0] ec, input logic [2:0] ea);
		axw(ttc_pkg::OFS_CTRL, 32'h7);
		osc(n, 1'b0);
		osc(2, 1'b1);
		repeat (10) @(posedge clk_in);
		rdc(ttc_pkg::OFS_RESULT, 32'(et));
		rdc(ttc_pkg::OFS_COUNT, 32'(ec));
		rdc(ttc_pkg::OFS_STATUS, {27'h0, ea[0], ea[1], ea[2], 2'b01});
		chk("alarms", 32'(ea), 32'({above_limit_alarm_out, below_limit_alarm_out, hysteresis_alarm_out}));
		$display("test conversion done");
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// --------
	// Scenarios
	// --------
	task automatic t_regs;
		logic [7:0] ofs [8] = '{ttc_pkg::OFS_UPPER, ttc_pkg::OFS_LOWER, ttc_pkg::OFS_BASE, ttc_pkg::OFS_SLOPE_INIT,
			ttc_pkg::OFS_SLOPE_STEP, ttc_pkg::OFS_GATE_LEN, ttc_pkg::OFS_RESULT, ttc_pkg::OFS_COUNT};
		logic [8:0] rvl [8] = '{ttc_pkg::UPPER_RST, ttc_pkg::LOWER_RST, ttc_pkg::BASE_RST, ttc_pkg::SLOPE_INIT_RST,
			ttc_pkg::SLOPE_STEP_RST, ttc_pkg::GATE_LEN_RST, ttc_pkg::TEMP_MIN, 9'h000};
		for (int i = 0; i < 8; i++)
			rdc(ofs[i], 32'(rvl[i]));
		rdc(8'h28, 32'h0, ttc_pkg::RESP_SLVERR);
		axw(8'h28, 32'h5, ttc_pkg::RESP_SLVERR);
		axw(ttc_pkg::OFS_RESULT, 32'h0);
		rdc(ttc_pkg::OFS_RESULT, 32'h192);
		$display("test register defaults done");
	endtask
	task automatic t_alarms;
		axw(ttc_pkg::OFS_BASE, 32'h3);
		axw(ttc_pkg::OFS_SLOPE_INIT, 32'h2);
		axw(ttc_pkg::OFS_GATE_LEN, 32'h2);
		axw(ttc_pkg::OFS_UPPER, 32'h194);
		axw(ttc_pkg::OFS_LOWER, 32'h190);
		convert_start_low(8, 9'h195, 9'h001, 3'b101);
		u_host.xfer(ttc_pkg::CMD_READ_TEMP, 1'b0, 9'h0, 12, rv);
		chk("serial temp", 32'h195, 32'(rv));
		u_host.xfer(ttc_pkg::CMD_READ_COUNT, 1'b0, 9'h0, 9, rv);
		chk("serial count", 32'h1, 32'(rv));
		u_host.xfer(ttc_pkg::CMD_READ_SLOPE, 1'b0, 9'h0, 9, rv);
		chk("serial slope read", 32'h2, 32'(rv));
		u_host.xfer(ttc_pkg::CMD_READ_COUNT, 1'b0, 9'h0, 9, rv);
		chk("serial slope", 32'h2, 32'(rv));
		convert_start_low(0, 9'h192, 9'h003, 3'b001);
		u_host.xfer(ttc_pkg::CMD_WRITE_LOWER, 1'b1, 9'h192, 9, rv);
		rdc(ttc_pkg::OFS_LOWER, 32'h192);
		convert_start_low(1, 9'h192, 9'h002, 3'b010);
		$display("test alarms and serial done");
	endtask
	task automatic t_stand_alone;
		axw(ttc_pkg::OFS_CTRL, 32'h0);
		u_host.convert_start_low_pulse();
		osc(3, 1'b0);
		osc(2, 1'b1);
		repeat (10) @(posedge clk_in);
		rdc(ttc_pkg::OFS_RESULT, 32'h193);
		$display("test stand-alone done");
	endtask
	task automatic t_timeout;
		axw(ttc_pkg::OFS_CTRL, 32'h3);
		u_host.xfer(ttc_pkg::CMD_START, 1'b0, 9'h0, 0, rv);
		repeat (2005) @(posedge clk_in);
		rdc(ttc_pkg::OFS_RESULT, 32'h192);
		rdc(ttc_pkg::OFS_STATUS, 32'h9);
		$display("test conversion limit done");
	endtask
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		#2000000;
		n_fail++;
		give_verdict();
	end
	initial begin
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in, low_tc_osc_in, high_tc_osc_in} = '0;
		rst_in = 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_alarms();
		t_stand_alone();
		t_timeout();
		give_verdict();
	end
endmodule
